// File: logic/lmcd_pkg.sv
package lmcd_pkg;
    // Command codes carried in the low seven bits of the command byte
    localparam logic [6:0] CMD_OTP_READ  = 7'h02;
    localparam logic [6:0] CMD_SAFE_PARK = 7'h04;
    localparam logic [6:0] CMD_HARD_STOP = 7'h05;
    localparam logic [6:0] CMD_POS_ZERO  = 7'h06;
    localparam logic [7:0] APP_CMD       = 8'h80;
    localparam logic       CMD_MARK      = 1'h1;

    // Frame identifiers and lengths
    localparam logic [5:0] ID_DIAG_REQ = 6'h3c;
    localparam logic [5:0] ID_DIAG_RSP = 6'h3d;
    localparam logic [3:0] LEN_WRITE   = 4'h2;
    localparam logic [3:0] LEN_PREP    = 4'h8;
    localparam logic [3:0] LEN_STATUS  = 4'h2;
    localparam logic [3:0] LEN_OTP     = 4'h8;

    // Register map of the plain register port
    localparam logic [3:0] REG_OTP_LAST  = 4'h7;
    localparam logic [3:0] REG_STATUS_ID = 4'h8;
    localparam logic [3:0] REG_FLAGS     = 4'h9;
    localparam logic [3:0] REG_NODE      = 4'ha;
    localparam logic [3:0] REG_STATE     = 4'hb;

    // Reset values
    localparam logic [7:0] OTP_RST       = 8'h00;
    localparam logic [5:0] STATUS_ID_RST = 6'h00;
    localparam logic [5:0] FLAGS_RST     = 6'h20;

    // Flag positions inside the six-bit flag vector
    localparam int FLG_WARN  = 0;
    localparam int FLG_SHUT  = 1;
    localparam int FLG_UNDER = 2;
    localparam int FLG_ELD   = 3;
    localparam int FLG_SL    = 4;
    localparam int FLG_VDD   = 5;

    // Byte positions, and bit positions of the pin field, in the read-back response
    localparam int OTP_HW_BYTE = 2;
    localparam int HW_LSB      = 4;
    localparam int HW_MSB      = 6;
    localparam int SP_HI_BYTE  = 5;
    localparam int SP_LO_BYTE  = 6;
endpackage : lmcd_pkg

// File: logic/lmcd_chk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lmcd_chk_if;
    logic [3:0]  len;
    logic [63:0] bytes;
    logic [7:0]  id;
    logic [7:0]  cks;
    logic        par_ok;

    modport user (output len, bytes, id, input cks, par_ok);
    modport calc (input len, bytes, id, output cks, par_ok);
endinterface : lmcd_chk_if
`default_nettype wire

// File: logic/lmcd_frame_check.sv
`timescale 1ns/1ps
`default_nettype none
module lmcd_frame_check (
    lmcd_chk_if.calc c
);
    logic [7:0] acc [0:8];

    // Carry-folding sum over the first len bytes
    assign acc[0] = 8'h00;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_sum
            logic [7:0] b;
            logic [8:0] s;
            assign b = (4'(i) < c.len) ? c.bytes[8*i +: 8] : 8'h00;
            assign s = {1'b0, acc[i]} + {1'b0, b};
            assign acc[i+1] = s[7:0] + {7'h00, s[8]};
        end
    endgenerate
    assign c.cks = ~acc[8];

    // Identifier parity in the two top bits
    logic p0;
    logic p1;
    assign p0 = c.id[0] ^ c.id[1] ^ c.id[2] ^ c.id[4];
    assign p1 = ~(c.id[1] ^ c.id[3] ^ c.id[4] ^ c.id[5]);
    assign c.par_ok = (c.id[6] == p0) && (c.id[7] == p1);
endmodule : lmcd_frame_check
`default_nettype wire

// File: logic/lmcd_decoder.sv
// Overview of operation
// - Read-back response shows live node address pin levels in the pin field.
// - Serving a quick status request clears the six reported fault flags afterwards.
// - Quick status answers two bytes: switch and address, then flags and temperature.
// - Two-byte write with code 0x04 and matching address requests the safe park move.
// - Link loss, end of initialisation and sleep entry request safe park internally.
// - Safe park requests are dropped while the priority logic blocks them.
// - Safe park frame with broadcast bit 0 acts on every node.
// - Two-byte commands decode from content only; master uses pointer 0000.
// - Coil fault triggers a hard stop and enters shutdown.
// - Hard stop while moving sets the missed steps flag.
// - Once stopped after a hard stop, target takes the actual position.
// - Master hard stop frame with matching address acts like the internal one.
// - Hard stop frame with broadcast bit 0 stops every node.
// - Two-byte write with code 0x06 zeroes actual and target positions.
// - Position zero command also sets reference done.
// - Position zero frame with broadcast bit 0 acts on every node.
// - Identifier top bits carry parity; received identifiers are checked.
// - Parameter read-back answers under identifier 0x3d.
`timescale 1ns/1ps
`default_nettype none
module lmcd_decoder
    import lmcd_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        frame_valid,
    input  wire logic [7:0]  frame_id,
    input  wire logic [3:0]  frame_len,
    input  wire logic [63:0] frame_data,
    input  wire logic [7:0]  frame_cks,
    input  wire logic        hdr_valid,
    input  wire logic [7:0]  hdr_id,
    output var  logic        resp_valid,
    output var  logic [3:0]  resp_len,
    output var  logic [63:0] resp_data,
    output var  logic [7:0]  resp_cks,
    input  wire logic [2:0]  node_addr_pin_levels,
    input  wire logic        motion_switch_state,
    input  wire logic        motor_moving,
    input  wire logic        coil_fault,
    input  wire logic        thermal_warning_in,
    input  wire logic        thermal_shutdown_in,
    input  wire logic        undervolt_in,
    input  wire logic [1:0]  temp_info,
    input  wire logic        link_lost,
    input  wire logic        init_done,
    input  wire logic        sleep_entry,
    input  wire logic        park_blocked,
    output var  logic        safe_park_req,
    output var  logic [10:0] safe_park_target,
    output var  logic        hard_stop_req,
    output var  logic        hold_stop_pos,
    output var  logic        position_zero_req,
    output var  logic        reference_done,
    output var  logic        shutdown_mode
);
    typedef enum logic {HS_IDLE, HS_WAIT} lmcd_hs_e;

    logic [7:0]  otp_r [0:7];
    logic [5:0]  status_id_r;
    logic [5:0]  flags_r;
    logic        armed_r;
    logic        coil_d_r;
    lmcd_hs_e    hs_r;
    lmcd_hs_e    hs_nxt;
    logic [7:0]  reg_rdata_r;
    logic        resp_valid_r;
    logic [3:0]  resp_len_r;
    logic [63:0] resp_data_r;
    logic [7:0]  resp_cks_r;
    logic        park_r;
    logic        stop_r;
    logic        hold_r;
    logic        zero_r;
    logic        refdone_r;
    logic        shut_r;

    lmcd_chk_if rx_c ();
    lmcd_chk_if tx_c ();

    lmcd_frame_check u_rx_chk (.c(rx_c.calc));
    lmcd_frame_check u_tx_chk (.c(tx_c.calc));

    // Received frame byte fields
    logic [6:0] node_addr;
    logic [7:0] fb1;
    logic [7:0] fb2;
    logic [7:0] fb3;
    assign node_addr = {otp_r[OTP_HW_BYTE][3:0], node_addr_pin_levels};
    assign fb1       = frame_data[7:0];
    assign fb2       = frame_data[15:8];
    assign fb3       = frame_data[23:16];

    assign rx_c.len   = frame_len;
    assign rx_c.bytes = frame_data;
    assign rx_c.id    = frame_id;

    // Frame is accepted only with good parity and checksum
    logic rx_ok;
    assign rx_ok = frame_valid && rx_c.par_ok && (rx_c.cks == frame_cks);

    // Two-byte writes decoded from content, any identifier
    logic wr_ok;
    logic wr_hit;
    logic [6:0] wr_cmd;
    assign wr_ok  = rx_ok && (frame_len == LEN_WRITE) && (fb1[7] == CMD_MARK);
    assign wr_cmd = fb1[6:0];
    assign wr_hit = wr_ok && (!fb2[7] || (fb2[6:0] == node_addr));

    logic park_wr;
    logic stop_wr;
    logic zero_wr;
    assign park_wr = wr_hit && (wr_cmd == CMD_SAFE_PARK);
    assign stop_wr = wr_hit && (wr_cmd == CMD_HARD_STOP);
    assign zero_wr = wr_hit && (wr_cmd == CMD_POS_ZERO);

    // Preparing frame that arms the parameter read-back
    logic prep_hit;
    assign prep_hit = rx_ok && (frame_len == LEN_PREP) && (frame_id[5:0] == ID_DIAG_REQ)
                      && (fb1 == APP_CMD) && (fb2 == {CMD_MARK, CMD_OTP_READ})
                      && (fb3 == {CMD_MARK, node_addr});

    // Internal and external event sources
    logic coil_rise;
    logic stop_evt;
    logic park_evt;
    assign coil_rise = coil_fault && !coil_d_r;
    assign stop_evt  = coil_rise || stop_wr;
    assign park_evt  = park_wr || link_lost || init_done || sleep_entry;

    // Header checks, parity via the second checker
    logic hdr_ok;
    logic stat_hit;
    logic otp_hit;
    assign tx_c.id  = hdr_id;
    assign hdr_ok   = hdr_valid && tx_c.par_ok;
    assign stat_hit = hdr_ok && (hdr_id[5:0] == status_id_r);
    assign otp_hit  = hdr_ok && !stat_hit && armed_r && (hdr_id[5:0] == ID_DIAG_RSP);

    // Quick status bytes
    logic [7:0] st_b1;
    logic [7:0] st_b2;
    assign st_b1 = {motion_switch_state, node_addr};
    assign st_b2 = {flags_r, temp_info};

    // Read-back bytes with live pin levels in the pin field
    logic [7:0] otp_b3;
    assign otp_b3 = {otp_r[2][7], node_addr_pin_levels, otp_r[2][3:0]};

    logic [63:0] otp_bytes;
    assign otp_bytes = {4'h0, otp_r[7][3:0], otp_r[6], otp_r[5], otp_r[4], otp_r[3],
                        otp_b3, 1'b1, otp_r[1][6:0], otp_r[0]};

    logic        resp_valid_nxt;
    logic [3:0]  resp_len_nxt;
    logic [63:0] resp_data_nxt;
    assign resp_valid_nxt = stat_hit || otp_hit;
    assign resp_len_nxt   = stat_hit ? LEN_STATUS : (otp_hit ? LEN_OTP : 4'h0);
    assign resp_data_nxt  = stat_hit ? {48'h0, st_b2, st_b1}
                          : (otp_hit ? otp_bytes : 64'h0);
    assign tx_c.len   = resp_len_nxt;
    assign tx_c.bytes = resp_data_nxt;

    // Flag set and clear; a set in the clearing cycle wins
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [5:0] flags_nxt;
    assign flag_set = {1'b0, stop_evt && motor_moving, coil_fault,
                       undervolt_in, thermal_shutdown_in, thermal_warning_in};
    assign flag_clr  = stat_hit ? 6'h3f : 6'h00;
    assign flags_nxt = flag_set | (flags_r & ~flag_clr);

    // Hard stop follow-up
    always_comb begin
        hs_nxt = hs_r;
        case (hs_r)
            HS_IDLE: begin
                if (stop_evt) begin
                    hs_nxt = HS_WAIT;
                end
            end
            HS_WAIT: begin
                // A fresh stop keeps waiting so it gets its own hold
                if (!motor_moving && !stop_evt) begin
                    hs_nxt = HS_IDLE;
                end
            end
            default: hs_nxt = HS_IDLE;
        endcase
    end

    // Register read selection
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr <= REG_OTP_LAST) ? otp_r[reg_addr[2:0]]
                  : (reg_addr == REG_STATUS_ID) ? {2'h0, status_id_r}
                  : (reg_addr == REG_FLAGS) ? {flags_r, temp_info}
                  : (reg_addr == REG_NODE) ? {1'b0, node_addr}
                  : (reg_addr == REG_STATE) ? {4'h0, armed_r, shut_r, refdone_r, 1'b0}
                  : 8'h00;

    // Software-loaded parameter store and status identifier
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int k = 0; k < 8; k++) begin
                otp_r[k] <= OTP_RST;
            end
            status_id_r <= STATUS_ID_RST;
        end else if (reg_wr) begin
            if (reg_addr <= REG_OTP_LAST) begin
                otp_r[reg_addr[2:0]] <= reg_wdata;
            end else if (reg_addr == REG_STATUS_ID) begin
                status_id_r <= reg_wdata[5:0];
            end
        end
    end

    // Response and register read data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata_r  <= 8'h00;
            resp_valid_r <= 1'b0;
            resp_len_r   <= 4'h0;
            resp_data_r  <= 64'h0;
            resp_cks_r   <= 8'h00;
        end else begin
            reg_rdata_r  <= reg_rd ? rd_mux : 8'h00;
            resp_valid_r <= resp_valid_nxt;
            resp_len_r   <= resp_len_nxt;
            resp_data_r  <= resp_data_nxt;
            resp_cks_r   <= resp_valid_nxt ? tx_c.cks : 8'h00;
        end
    end

    // Command outputs and internal state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_r   <= FLAGS_RST;
            armed_r   <= 1'b0;
            coil_d_r  <= 1'b0;
            hs_r      <= HS_IDLE;
            park_r    <= 1'b0;
            stop_r    <= 1'b0;
            hold_r    <= 1'b0;
            zero_r    <= 1'b0;
            refdone_r <= 1'b0;
            shut_r    <= 1'b0;
        end else begin
            flags_r   <= flags_nxt;
            armed_r   <= prep_hit || (armed_r && !otp_hit);
            coil_d_r  <= coil_fault;
            hs_r      <= hs_nxt;
            park_r    <= park_evt && !park_blocked;
            stop_r    <= stop_evt;
            hold_r    <= (hs_r == HS_WAIT) && !motor_moving;
            zero_r    <= zero_wr;
            refdone_r <= refdone_r || zero_wr;
            shut_r    <= shut_r || coil_rise;
        end
    end

    assign reg_rdata         = reg_rdata_r;
    assign resp_valid        = resp_valid_r;
    assign resp_len          = resp_len_r;
    assign resp_data         = resp_data_r;
    assign resp_cks          = resp_cks_r;
    assign safe_park_req     = park_r;
    assign safe_park_target  = {otp_r[SP_HI_BYTE][7:5], otp_r[SP_LO_BYTE]};
    assign hard_stop_req     = stop_r;
    assign hold_stop_pos     = hold_r;
    assign position_zero_req = zero_r;
    assign reference_done    = refdone_r;
    assign shutdown_mode     = shut_r;

    // Checks on the decoded behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_stop;
        stop_evt;
    endsequence
    sequence s_rest;
        !motor_moving;
    endsequence

    status_answer_a: assert property (stat_hit |=> resp_valid && resp_len == LEN_STATUS
        && resp_data[7:0] == {$past(motion_switch_state), $past(node_addr)})
        else $error("quick status answer wrong");
    flag_clear_a: assert property (stat_hit && flag_set == 6'h00 |=> flags_r == 6'h00)
        else $error("flags not cleared after status");
    pin_levels_a: assert property (otp_hit |=> resp_len == LEN_OTP
        && resp_data[8*OTP_HW_BYTE+HW_MSB -: 3] == $past(node_addr_pin_levels))
        else $error("pin levels missing in read-back");
    park_frame_a: assert property (park_wr && !park_blocked |=> safe_park_req)
        else $error("safe park frame not executed");
    park_block_a: assert property (park_blocked |=> !safe_park_req)
        else $error("blocked safe park passed");
    park_internal_a: assert property ((link_lost || init_done || sleep_entry)
        && !park_blocked |=> safe_park_req)
        else $error("internal safe park missing");
    coil_stop_a: assert property (coil_rise |=> hard_stop_req && shutdown_mode)
        else $error("coil fault did not stop");
    missed_steps_a: assert property (stop_evt && motor_moving |=> flags_r[FLG_SL])
        else $error("missed steps flag not set");
    hold_pos_a: assert property (s_stop ##1 s_rest |=> hold_stop_pos)
        else $error("stop position not held");
    pos_zero_a: assert property (zero_wr |=> position_zero_req && reference_done)
        else $error("position zero not executed");
    bad_cks_a: assert property (frame_valid && rx_c.cks != frame_cks && !coil_rise
        |=> !hard_stop_req && !position_zero_req)
        else $error("bad checksum frame executed");
    hdr_parity_a: assert property (hdr_valid && !tx_c.par_ok |=> !resp_valid)
        else $error("answered bad parity header");
endmodule : lmcd_decoder
`default_nettype wire

// File: tb/lmcd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmcd_master_model (
    input  wire logic        ref_clk,
    output var  logic        frame_valid,
    output var  logic [7:0]  frame_id,
    output var  logic [3:0]  frame_len,
    output var  logic [63:0] frame_data,
    output var  logic [7:0]  frame_cks,
    output var  logic        hdr_valid,
    output var  logic [7:0]  hdr_id
);
    // Bus idle at time zero
    initial begin
        frame_valid = 1'b0;
        frame_id    = 8'h00;
        frame_len   = 4'h0;
        frame_data  = 64'h0;
        frame_cks   = 8'h00;
        hdr_valid   = 1'b0;
        hdr_id      = 8'h00;
    end

    // Identifier with its two parity bits on top
    function automatic logic [7:0] with_par(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction : with_par

    // Inverted carry-wrapped sum of the data bytes
    function automatic logic [7:0] cks(input logic [3:0] n, input logic [63:0] d);
        logic [8:0] s;
        s = 9'h000;
        for (int k = 0; k < 8; k++) begin
            if (k < n) s = {1'b0, s[7:0]} + {1'b0, d[8*k +: 8]} + {8'h00, s[8]};
        end
        s = {1'b0, s[7:0]} + {8'h00, s[8]};
        return ~s[7:0];
    endfunction : cks

    // One frame; bad[0] spoils the checksum, bad[1] the parity
    task automatic send_frame(input logic [5:0] id, input logic [3:0] len,
                              input logic [63:0] data, input logic [1:0] bad);
        @(posedge ref_clk);
        frame_valid <= 1'b1;
        frame_id    <= with_par(id) ^ {bad[1], 7'h00};
        frame_len   <= len;
        frame_data  <= data;
        frame_cks   <= cks(len, data) ^ {7'h00, bad[0]};
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        frame_data  <= ~data; // Released data and checksum lines never keep the last value
        frame_cks   <= ~frame_cks;
    endtask : send_frame

    // Header for which the slave may answer; bad spoils the parity
    task automatic send_hdr(input logic [5:0] id, input logic bad);
        @(posedge ref_clk);
        hdr_valid <= 1'b1;
        hdr_id    <= with_par(id) ^ {bad, 7'h00};
        @(posedge ref_clk);
        hdr_valid <= 1'b0;
        hdr_id    <= ~hdr_id;
    endtask : send_hdr
endmodule : lmcd_master_model
`default_nettype wire

// File: tb/test_lin_motor_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_lin_motor_command_decoder
    import lmcd_pkg::*;
;
    localparam logic [6:0] ADDR    = 7'h2b;
    localparam logic [5:0] STAT_ID = 6'h11;
    logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, frame_id, frame_cks, hdr_id, resp_cks, r_cks, h0;
    logic frame_valid, hdr_valid, resp_valid, safe_park_req, hard_stop_req, hold_stop_pos;
    logic position_zero_req, reference_done, shutdown_mode;
    logic [3:0] frame_len, resp_len, r_len;
    logic [63:0] frame_data, resp_data, r_data;
    logic [10:0] safe_park_target;
    logic [2:0] pins = 3'b011, trig = 3'b000;
    logic [1:0] tinfo = 2'b10;
    logic msw = 1'b1, moving = 1'b0, coil = 1'b0, blocked = 1'b0;
    logic [2:0] env_in = 3'b000;
    logic [7:0] n_evt [4] = '{default: 8'h00};
    logic [7:0] n_resp = 8'h00;
    int n_mismatch = 0, checks_done = 0;

    lmcd_decoder dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_valid(frame_valid), .frame_id(frame_id), .frame_len(frame_len),
        .frame_data(frame_data), .frame_cks(frame_cks), .hdr_valid(hdr_valid),
        .hdr_id(hdr_id), .resp_valid(resp_valid), .resp_len(resp_len),
        .resp_data(resp_data), .resp_cks(resp_cks), .node_addr_pin_levels(pins),
        .motion_switch_state(msw), .motor_moving(moving), .coil_fault(coil),
        .thermal_warning_in(env_in[0]), .thermal_shutdown_in(env_in[1]),
        .undervolt_in(env_in[2]),
        .temp_info(tinfo), .link_lost(trig[0]), .init_done(trig[1]),
        .sleep_entry(trig[2]), .park_blocked(blocked), .safe_park_req(safe_park_req),
        .safe_park_target(safe_park_target), .hard_stop_req(hard_stop_req),
        .hold_stop_pos(hold_stop_pos), .position_zero_req(position_zero_req),
        .reference_done(reference_done), .shutdown_mode(shutdown_mode));
    lmcd_master_model m (.ref_clk(ref_clk), .frame_valid(frame_valid),
        .frame_id(frame_id), .frame_len(frame_len), .frame_data(frame_data),
        .frame_cks(frame_cks), .hdr_valid(hdr_valid), .hdr_id(hdr_id));

    always #50 ref_clk = ~ref_clk;

    // Count command pulses and capture each answer
    always @(posedge ref_clk) begin
        n_evt[0] <= n_evt[0] + 8'(safe_park_req === 1'b1);
        n_evt[1] <= n_evt[1] + 8'(hard_stop_req === 1'b1);
        n_evt[2] <= n_evt[2] + 8'(position_zero_req === 1'b1);
        n_evt[3] <= n_evt[3] + 8'(hold_stop_pos === 1'b1);
        if (resp_valid === 1'b1) begin
            n_resp <= n_resp + 8'h01;
            r_len  <= resp_len;
            r_data <= resp_data;
            r_cks  <= resp_cks;
        end
    end

    task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h got %h", nm, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", {56'h0, exp}, {56'h0, reg_rdata});
    endtask : reg_read

    // Header, then compare how many answers came back
    task automatic ask(input logic [5:0] id, input logic [7:0] n_exp, input logic bad);
        logic [7:0] n0;
        n0 = n_resp;
        m.send_hdr(id, bad);
        repeat (3) @(posedge ref_clk);
        check("answer count", {56'h0, n0 + n_exp}, {56'h0, n_resp});
    endtask : ask

    task automatic status(input logic [7:0] b2);
        ask(STAT_ID, 8'h01, 1'b0);
        check("status len", {60'h0, LEN_STATUS}, {60'h0, r_len});
        check("status data", {48'h0, b2, msw, ADDR}, r_data);
        check("status cks", {56'h0, m.cks(LEN_STATUS, {b2, msw, ADDR})}, {56'h0, r_cks});
    endtask : status

    task automatic cmd(input logic [6:0] c, input logic [7:0] ad, input logic [1:0] bad);
        m.send_frame(6'h00, LEN_WRITE, {48'hffff_ffff_ffff, ad, CMD_MARK, c}, bad);
        repeat (3) @(posedge ref_clk);
    endtask : cmd

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(2_000_000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        reg_write(4'h9, 8'hff);
        reg_read(4'h9, {FLAGS_RST, tinfo});
        reg_read(4'hc, 8'h00);
        reg_write(4'h2, 8'h05);
        reg_write(4'h5, 8'ha0);
        reg_write(4'h6, 8'h5c);
        reg_write(4'h8, {2'b00, STAT_ID});
        reg_read(4'ha, {1'b0, ADDR});
        // Spoilt parity and a foreign identifier get no answer
        ask(STAT_ID, 8'h00, 1'b1);
        ask(6'h12, 8'h00, 1'b0);
        status(8'h82);
        status(8'h02);
        env_in <= 3'b111;
        repeat (2) @(posedge ref_clk);
        env_in <= 3'b000;
        status(8'h1e);
        status(8'h02);
        // Read-back armed, then pins move before the answer
        m.send_frame(ID_DIAG_REQ, LEN_PREP,
                     {40'hff_ffff_ffff, 1'b1, ADDR, 8'h82, APP_CMD}, 2'b00);
        pins <= 3'b110;
        ask(ID_DIAG_RSP, 8'h01, 1'b0);
        check("readback len", {60'h0, LEN_OTP}, {60'h0, r_len});
        check("readback data", 64'h005c_a000_0065_8000, r_data);
        check("readback cks", {56'h0, m.cks(LEN_OTP, 64'h005c_a000_0065_8000)},
              {56'h0, r_cks});
        ask(ID_DIAG_RSP, 8'h00, 1'b0);
        pins <= 3'b011;
        // Each command addressed, broadcast, foreign, bad checksum, bad parity
        for (int c = 0; c < 3; c++) begin
            cmd(7'(CMD_SAFE_PARK + c), {1'b1, ADDR}, 2'b00);
            cmd(7'(CMD_SAFE_PARK + c), 8'h01, 2'b00);
            cmd(7'(CMD_SAFE_PARK + c), 8'h81, 2'b00);
            cmd(7'(CMD_SAFE_PARK + c), {1'b1, ADDR}, 2'b01);
            cmd(7'(CMD_SAFE_PARK + c), {1'b1, ADDR}, 2'b10);
            check("command pulses", 64'h2, {56'h0, n_evt[c]});
        end
        check("park target", 64'h55c, {53'h0, safe_park_target});
        check("reference done", 64'h1, {63'h0, reference_done});
        blocked <= 1'b1;
        cmd(CMD_SAFE_PARK, {1'b1, ADDR}, 2'b00);
        trig <= 3'b111;
        @(posedge ref_clk);
        trig <= 3'b000;
        repeat (3) @(posedge ref_clk);
        check("blocked park", 64'h2, {56'h0, n_evt[0]});
        blocked <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            trig <= 3'(1 << k);
            @(posedge ref_clk);
            trig <= 3'b000;
            repeat (2) @(posedge ref_clk);
        end
        check("internal park", 64'h5, {56'h0, n_evt[0]});
        moving <= 1'b1;
        h0 = n_evt[3];
        cmd(CMD_HARD_STOP, {1'b1, ADDR}, 2'b00);
        status(8'h42);
        check("hold while moving", {56'h0, h0}, {56'h0, n_evt[3]});
        moving <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("hold at rest", {56'h0, h0 + 8'h01}, {56'h0, n_evt[3]});
        coil <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("stop pulses", 64'h4, {56'h0, n_evt[1]});
        check("shutdown", 64'h1, {63'h0, shutdown_mode});
        coil <= 1'b0;
        status(8'h22);
        reg_read(4'hb, 8'h06);
        finish_test();
    end
endmodule : test_lin_motor_command_decoder
`default_nettype wire
